// ---- design/sysconf_defines.svh ----
// constants for the system configuration block
`ifndef SYSCONF_DEFINES_SVH
`define SYSCONF_DEFINES_SVH
// apb byte offsets
`define OFF_CFG        12'h000
`define OFF_STRAP      12'h004
`define OFF_ARB_EXT    12'h008
`define OFF_ACK        12'h00c
`define OFF_DECODE     12'h010
`define OFF_MOD_ARB    12'h014
`define OFF_CS_PORT    12'h018
// config register field positions
`define CFG_ARB_LSB    0
`define CFG_SHOW_LSB   4
`define CFG_MAP_BIT    6
`define CFG_SUPV_BIT   7
// reset values
`define CFG_RESET      32'h0000_008f
`define SIM_ARB_RESET  4'hf
`define MOD_ARB_RESET  4'h0
// clocks after release during which the strap filter may still load
`define STRAP_WINDOW   3'h5
// register block base upper bits (m111) and middle address bits (ff)
`define BLK_LOW_BITS   3'h7
`define BLK_MID        8'hff
// count of other interrupt modules and chip selects
`define N_MODS         4
`define N_CS           12
`endif

// ---- design/sysconf_pkg.sv ----
// types for the system configuration block
package sysconf_pkg;
	typedef enum logic [1:0] {
		SHOW_OFF_ARB  = 2'b00,
		SHOW_NO_ARB   = 2'b01,
		SHOW_ARB      = 2'b10,
		SHOW_ARB_HALT = 2'b11
	} show_mode_t;
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_RUN  = 2'b01,
		ARB_DONE = 2'b10
	} arb_state_t;
endpackage

// ---- design/system_config.sv ----
// system configuration: reset straps, register map, irq arbitration, show cycles
// Overview of operation
// [RL1] data pins sampled during reset latch operating configuration; high default, low alternate
// [RL2] clock-mode strap high picks synth oscillator, low picks crystal input
// [RL3] breakpoint pin low at reset enables background debug mode
// [RL4] data0 low gives 8-bit boot select; data8/9 low give ports
// [RL5] other module pins default to input ports out of reset
// [RL6] registers decode in one 4-Kbyte block placed by module map bit
// [RL7] block address bits 23..20 equal m111
// [RL8] unused block addresses go external; reserved blocks do not
// [RL9] some registers reachable only with supervisor privilege
// [RL10] equal-level requests resolved by serial bitwise contention of priority fields
// [RL11] contention runs on every acknowledge, even a single request
// [RL12] zero priority field wins nothing; recognized zero request is spurious
// [RL13] integration module field arbitrates external requests
// [RL14] reset loads integration field 1111, others 0000
// [RL15] show cycles drive internal transfers to external pins
// [RL16] show field selects show cycles, arbitration and halt on grant
// [RL17] twelve chip selects, also usable as output port
// [RL18] test_mode_strap low at reset enables slave mode; read-only flag
// [RL19] internal bus has 24 address and 16 data lines
// [RL20] strapping holds mode pins steady for whole reset
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "sysconf_defines.svh"
module system_config (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// strap pins, held during reset
	input  wire logic [11:0]              data_strap_pins,
	input  wire logic                     clock_source_strap,
	input  wire logic                     breakpoint_pin,
	// internal bus address decode
	input  wire logic [23:0]              imb_addr, // RL19
	input  wire logic                     imb_supervisor,
	input  wire logic                     imb_reserved,
	output logic                          imb_internal_hit,
	output logic                          imb_external,
	output logic                          imb_priv_fault,
	// interrupt arbitration
	input  wire logic                     irq_ack,
	input  wire logic [`N_MODS-1:0]       mod_irq_req,
	input  wire logic                     ext_irq_req,
	output logic      [`N_MODS:0]         arb_winner,
	output logic                          arb_done,
	output logic                          arb_spurious,
	// strap-derived configuration
	output logic                          sel_synth_oscillator,
	output logic                          background_enabled,
	output logic                          boot_8bit,
	output logic                          port_e_mode,
	output logic                          port_f_mode,
	output logic                          slave_enabled_flag,
	output logic      [`N_MODS-1:0]       module_pins_are_ports,
	// show cycles and external arbitration
	output sysconf_pkg::show_mode_t       show_cycle_select,
	output logic                          show_cycles_on,
	output logic                          ext_arb_enabled,
	output logic                          halt_on_grant,
	output logic      [`N_CS-1:0]         cs_port_data
);
	import sysconf_pkg::*;

	// strap capture: three stages, change accepted when stage 2 and 3 agree
	logic [13:0] s1_r, s2_r, s3_r, strap_r, s_nxt;
	logic [2:0]  strap_win_r, strap_win_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [`N_MODS*4-1:0] marb_r, marb_nxt;
	logic [`N_CS-1:0] csp_r, csp_nxt;
	logic [31:0] rd_nxt, prdata_r;
	// contention state
	arb_state_t  st_r, st_nxt;
	logic [1:0]  bit_r, bit_nxt;
	logic [`N_MODS:0] cand_r, cand_nxt;
	logic        spur_r, spur_nxt;
	logic [3:0]  prio [0:`N_MODS];
	logic        wr;
	logic [`N_MODS:0] ones, fin, nz;
	logic        live;

	// strap sampling: the window stays open a few clocks past release so the filter settles
	always_comb begin
		s_nxt         = strap_r;
		strap_win_nxt = strap_win_r;
		if (strap_win_r != 3'h0)
			strap_win_nxt = strap_win_r - 3'h1;
		if (strap_win_r != 3'h0 && (s2_r == s3_r))
			s_nxt = s3_r; // RL1
	end
	// filter preset to all ones, the default level, so an unsettled pin never reads as low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r        <= 14'h3fff;
			s2_r        <= 14'h3fff;
			s3_r        <= 14'h3fff;
			strap_r     <= 14'h3fff;
			strap_win_r <= `STRAP_WINDOW;
		end else begin
			s1_r        <= {breakpoint_pin, clock_source_strap, data_strap_pins};
			s2_r        <= s1_r;
			s3_r        <= s2_r;
			strap_r     <= s_nxt;
			strap_win_r <= strap_win_nxt;
		end
	end
	// strap decodes, low selects alternate function
	// these stay fixed once the window closes; software sees the raw levels at the strap offset
	assign boot_8bit            = ~strap_r[0];   // RL4
	assign port_e_mode          = ~strap_r[8];   // RL4
	assign port_f_mode          = ~strap_r[9];   // RL4
	assign slave_enabled_flag   = ~strap_r[11];  // RL18
	assign sel_synth_oscillator = strap_r[12];   // RL2
	assign background_enabled   = ~strap_r[13];  // RL3
	assign module_pins_are_ports = {`N_MODS{1'b1}}; // RL5

	// apb register writes
	// writes land in the access phase; pready is tied high so there are no wait states
	assign wr = psel && penable && pwrite;
	always_comb begin
		cfg_nxt  = cfg_r;
		marb_nxt = marb_r;
		csp_nxt  = csp_r;
		if (wr && paddr == `OFF_CFG)
			cfg_nxt = {24'h0, pwdata[7:0]};
		if (wr && paddr == `OFF_MOD_ARB)
			marb_nxt = pwdata[`N_MODS*4-1:0];
		if (wr && paddr == `OFF_CS_PORT)
			csp_nxt = pwdata[`N_CS-1:0]; // RL17
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r  <= `CFG_RESET;                 // RL14
			marb_r <= {`N_MODS{`MOD_ARB_RESET}};  // RL14
			csp_r  <= '0;
		end else begin
			cfg_r  <= cfg_nxt;
			marb_r <= marb_nxt;
			csp_r  <= csp_nxt;
		end
	end

	// apb read mux, registered for data output
	always_comb begin
		rd_nxt = prdata_r;
		// capture in the setup cycle so the word already stands in the access phase
		if (psel && !penable) begin
			case (paddr)
			`OFF_CFG:     rd_nxt = cfg_r;
			`OFF_STRAP:   rd_nxt = {18'h0, strap_r};
			`OFF_ACK:     rd_nxt = {24'h0, spur_r, arb_done, 1'b0, arb_winner};
			`OFF_MOD_ARB: rd_nxt = {16'h0, marb_r};
			`OFF_CS_PORT: rd_nxt = {20'h0, csp_r};
			default:      rd_nxt = 32'h0;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0;
		else
			prdata_r <= rd_nxt;
	end
	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	// unmapped offsets answer with an error in the access phase and read as zero
	assign pslverr = psel && penable && !(paddr == `OFF_CFG || paddr == `OFF_STRAP
		|| paddr == `OFF_ACK || paddr == `OFF_MOD_ARB || paddr == `OFF_CS_PORT);

	// register block decode
	// the block sits at m111 ff in the top twelve bits; m follows the map bit live
	always_comb begin
		imb_internal_hit = (imb_addr[23:20] == {cfg_r[`CFG_MAP_BIT], `BLK_LOW_BITS}) // RL7
			&& (imb_addr[19:12] == `BLK_MID); // RL6
		imb_priv_fault = imb_internal_hit && cfg_r[`CFG_SUPV_BIT] && !imb_supervisor; // RL9
		imb_external   = !imb_internal_hit || !imb_reserved; // RL8
	end

	// show-cycle control
	// mode 01 is the only one that locks out external masters
	assign show_cycle_select = show_mode_t'(cfg_r[5:4]);        // RL16
	assign show_cycles_on    = show_cycle_select != SHOW_OFF_ARB; // RL15
	assign ext_arb_enabled   = show_cycle_select != SHOW_NO_ARB;  // RL16
	assign halt_on_grant     = show_cycle_select == SHOW_ARB_HALT;
	assign cs_port_data      = csp_r;

	// arbitration fields: index 0 is this module on behalf of external requests
	always_comb begin
		prio[0] = cfg_r[3:0]; // RL13
		for (int i = 0; i < `N_MODS; i++)
			prio[i+1] = marb_r[i*4 +: 4];
		// a zero field may take part in contention but can never be served
		for (int i = 0; i <= `N_MODS; i++)
			nz[i] = prio[i] != 4'h0;
	end

	// serial contention, msb first, one bit per clock
	always_comb begin
		st_nxt   = st_r;
		bit_nxt  = bit_r;
		cand_nxt = cand_r;
		spur_nxt = spur_r;
		// scratch values default so no latch is inferred
		ones     = '0;
		fin      = cand_r;
		live     = 1'b0;
		case (st_r)
		ARB_IDLE: begin
			// requests are levels; they are frozen into the candidate set at the acknowledge
			if (irq_ack) begin // RL11
				cand_nxt = {mod_irq_req, ext_irq_req};
				bit_nxt  = 2'd3;
				spur_nxt = 1'b0;
				st_nxt   = ARB_RUN;
			end
		end
		ARB_RUN: begin
			for (int i = 0; i <= `N_MODS; i++)
				ones[i] = cand_r[i] && prio[i][bit_r];
			// a bit on which nobody drives a one eliminates nobody
			if (ones != '0)
				fin = ones; // RL10
			cand_nxt = fin;
			bit_nxt  = bit_r - 2'd1;
			if (bit_r == 2'd0) begin
				st_nxt   = ARB_DONE;
				live     = (fin & nz) != '0;
				spur_nxt = !live; // RL12
			end
		end
		ARB_DONE: st_nxt = ARB_IDLE;
		default:  st_nxt = ARB_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r   <= ARB_IDLE;
			bit_r  <= 2'd0;
			cand_r <= '0;
			spur_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			bit_r  <= bit_nxt;
			cand_r <= cand_nxt;
			spur_r <= spur_nxt;
		end
	end
	assign arb_done     = st_r == ARB_DONE;
	assign arb_spurious = arb_done && spur_r;
	assign arb_winner   = (arb_done && !spur_r) ? cand_r : '0;

	// checks
	a_map_base: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		imb_addr[23:12] == 12'h7ff && !cfg_r[6] |-> imb_internal_hit) else $error("map0 miss");
	a_map_high: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		imb_internal_hit |-> imb_addr[22:20] == 3'h7) else $error("bad block");
	a_arb_len: assert property (@(posedge pclk) disable iff (!presetn) // RL11
		st_r == ARB_IDLE && irq_ack |-> ##5 arb_done) else $error("arb length");
	a_arb_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL12
		arb_done && !spur_r |-> cand_r != '0 && (cand_r & nz) == cand_r) else $error("no winner");
	a_show_arb: assert property (@(posedge pclk) disable iff (!presetn) // RL16
		cfg_r[5:4] == 2'b01 |-> !ext_arb_enabled && show_cycles_on) else $error("show mode");
	a_priv_blk: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		imb_priv_fault |-> !imb_supervisor) else $error("priv fault");
	a_ext_resv: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		imb_internal_hit && imb_reserved |-> !imb_external) else $error("reserved external");
	a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL1
		strap_win_r == 3'h0 |=> $stable(strap_r)) else $error("strap moved");

	// checks: block placement, routing and privilege
	a_map_top: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		imb_addr[23:12] == 12'hfff && cfg_r[6] |-> imb_internal_hit) else $error("map1 miss");
	a_map_out: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		!imb_internal_hit |-> imb_external) else $error("outside not external");
	a_priv_user: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		imb_internal_hit && cfg_r[7] && !imb_supervisor |-> imb_priv_fault) else $error("user not blocked");

	// checks: serial contention
	a_arb_bits: assert property (@(posedge pclk) disable iff (!presetn) // RL11
		st_r == ARB_IDLE && irq_ack |=> st_r == ARB_RUN && bit_r == 2'd3) else $error("arb start");
	a_arb_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RL11
		arb_done |=> !arb_done) else $error("done too long");
	a_arb_narrow: assert property (@(posedge pclk) disable iff (!presetn) // RL10
		st_r == ARB_RUN |=> (cand_r & ~$past(cand_r)) == '0) else $error("candidate added");
	a_arb_spur: assert property (@(posedge pclk) disable iff (!presetn) // RL12
		arb_done && spur_r |-> (cand_r & nz) == '0 && arb_winner == '0) else $error("bad spurious");

	// checks: show cycles and straps
	a_show_halt: assert property (@(posedge pclk) disable iff (!presetn) // RL16
		cfg_r[5:4] == 2'b11 |-> halt_on_grant && ext_arb_enabled && show_cycles_on) else $error("halt mode");
	a_show_off: assert property (@(posedge pclk) disable iff (!presetn) // RL15
		cfg_r[5:4] == 2'b00 |-> !show_cycles_on && ext_arb_enabled && !halt_on_grant) else $error("show off");
	a_slave_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL18
		strap_win_r == 3'h0 |=> $stable(slave_enabled_flag) && $stable(boot_8bit)) else $error("flag moved");
endmodule

// ---- testbench/strap_partner.sv ----
// far side: reset strapping and interrupt requesters
`timescale 1ns/10ps
`include "sysconf_defines.svh"
module strap_partner (
	// levels commanded by the bench
	input  wire logic [13:0]        strap_set,
	input  wire logic [`N_MODS:0]   req_set,
	// pins toward the block
	output logic      [11:0]        data_strap_pins,
	output logic                    clock_source_strap,
	output logic                    breakpoint_pin,
	output logic      [`N_MODS-1:0] mod_irq_req,
	output logic                    ext_irq_req
);
	// straps are set before reset and never move afterwards
	assign {breakpoint_pin, clock_source_strap, data_strap_pins} = strap_set;
	// requests stay as levels; bit 0 is the external line
	assign {mod_irq_req, ext_irq_req} = req_set;
endmodule

// ---- testbench/system_config_tb.sv ----
// self-checking bench for the system configuration block
`timescale 1ns/10ps
`include "sysconf_defines.svh"
`define CHK(n, e, g) check(n, 33'(e), 33'(g))
module system_config_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        irq_ack = 0, sup = 0, res = 0, pready, pslverr;
	logic [11:0] paddr = 0, dp, cs;
	logic [31:0] pwdata = 0, prdata;
	logic [23:0] ia = 0;
	logic [13:0] strap_set = 0;
	logic [4:0]  req_set = 0, win;
	logic [3:0]  mp, mreq;
	logic [1:0]  shs;
	logic        hit, ext, pf, done, spur, osc, bkg, b8, pe, pf2, slv, sh_on, xarb, halt, xreq, ck_s, bk_p;
	logic [32:0] rd_q[$];
	logic [5:0]  arb_q[$];
	int          err_total = 0;
	int          samples_checked = 0;
	strap_partner u_far (.strap_set(strap_set), .req_set(req_set), .data_strap_pins(dp),
		.clock_source_strap(ck_s), .breakpoint_pin(bk_p), .mod_irq_req(mreq), .ext_irq_req(xreq));
	system_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.data_strap_pins(dp), .clock_source_strap(ck_s), .breakpoint_pin(bk_p), .imb_addr(ia),
		.imb_supervisor(sup), .imb_reserved(res), .imb_internal_hit(hit), .imb_external(ext),
		.imb_priv_fault(pf), .irq_ack(irq_ack), .mod_irq_req(mreq), .ext_irq_req(xreq), .arb_winner(win),
		.arb_done(done), .arb_spurious(spur), .sel_synth_oscillator(osc), .background_enabled(bkg),
		.boot_8bit(b8), .port_e_mode(pe), .port_f_mode(pf2), .slave_enabled_flag(slv),
		.module_pins_are_ports(mp), .show_cycle_select(shs), .show_cycles_on(sh_on),
		.ext_arb_enabled(xarb), .halt_on_grant(halt), .cs_port_data(cs));
	task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one apb transfer; a read notes its expected {pslverr, prdata}
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e = 0);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) rd_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 50);
		if (!pready) begin
			err_total++;
			results;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// raise requests, acknowledge, wait for the noted result to be taken
	task automatic arb(input logic [4:0] rq, input logic [19:0] f);
		logic [3:0] mx;
		logic [4:0] w;
		mx = 0;
		w = 0;
		for (int i = 0; i < 5; i++) if (rq[i] && f[4*i +: 4] > mx) mx = f[4*i +: 4];
		for (int i = 0; i < 5; i++) w[i] = rq[i] && f[4*i +: 4] == mx;
		arb_q.push_back(mx == 0 ? 6'h20 : {1'b0, w});
		@(posedge pclk);
		req_set <= rq;
		@(posedge pclk);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		for (int n = 0; arb_q.size() > 0; n++) begin
			if (n == 20) begin
				err_total++;
				results;
			end
			@(posedge pclk);
		end
	endtask
	// take the oldest note whenever the block answers
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rd_q.size() > 0)
			`CHK("read", rd_q.pop_front(), {pslverr, prdata});
		if (done || spur)
			`CHK("arb", arb_q.size() ? arb_q.pop_front() : 6'h3f, {spur, spur ? 5'h0 : win});
	end
	initial begin
		forever #4 pclk = ~pclk;
	end
	// reset with random straps held steady, then walk the features
	initial begin
		logic [19:0] f;
		logic [23:0] a;
		void'($urandom(32'hee2f));
		strap_set = 14'($urandom);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		`CHK("straps", {~strap_set[13], strap_set[12], ~strap_set[11], ~strap_set[9:8], ~strap_set[0]},
			{bkg, osc, slv, pf2, pe, b8});
		`CHK("ports", 4'hf, mp);
		apb(0, `OFF_STRAP, 0, {19'h0, strap_set});
		apb(0, `OFF_CFG, 0, 33'h8f);
		apb(0, `OFF_MOD_ARB, 0, 0);
		apb(0, `OFF_ARB_EXT, 0, 33'h1_0000_0000);
		f = 20'($urandom);
		apb(1, `OFF_CS_PORT, {20'h0, f[11:0]});
		apb(0, `OFF_CS_PORT, 0, {21'h0, f[11:0]});
		`CHK("cs", f[11:0], cs);
		for (int s = 0; s < 4; s++) begin
			apb(1, `OFF_CFG, 32'hffff_ff8f | (s << 4));
			apb(0, `OFF_CFG, 0, 33'h8f | (s << 4));
			`CHK("show", {2'(s), s != 0, s != 1, s == 3}, {shs, sh_on, xarb, halt});
		end
		for (int m = 0; m < 2; m++) begin
			apb(1, `OFF_CFG, 32'h8f | (m << 6));
			for (int k = 0; k < 6; k++) begin
				a = {1'(m), 11'h7ff, 12'($urandom)};
				if (k == 3) a[23] = ~a[23];
				if (k > 3) a = 24'($urandom);
				@(posedge pclk);
				ia <= a;
				sup <= 1'($urandom);
				res <= 1'($urandom);
				@(negedge pclk);
				`CHK("decode", {a[23:12] == {1'(m), 11'h7ff}, a[23:12] != {1'(m), 11'h7ff} || !res,
					a[23:12] == {1'(m), 11'h7ff} && !sup}, {hit, ext, pf});
			end
		end
		apb(1, `OFF_CFG, 32'h8f);
		arb(5'b00010, 20'h0000f);
		apb(1, `OFF_MOD_ARB, 32'h5a35);
		arb(5'b00100, 20'h5a35f);
		arb(5'b11010, 20'h5a35f);
		apb(1, `OFF_CFG, 32'h85);
		arb(5'b10011, 20'h5a355);
		results;
	end
endmodule
